// ---- design/tmca_channel.v ----
// Purpose: channel A control of a 10-bit up/down timer
// Assumes: Avalon-MM slave, 40 MHz clk_in, counter ticks every clock
// Notes:   output pin and capture input share chan_a_pin
`timescale 1ns/1ps
`default_nettype none
`include "tmca_regs.vh"

// Notes on behaviour
// R01: mode field selects compare, capture, PWM, timer
// R02: software stops timer before mode change
// R03: timer mode needs pin output disabled
// R04: compare match: keep, low, high, toggle
// R05: requested level equal initial gives no change
// R06: timer on rising restores initial level
// R07: PWM mode: inactive, active, PWM, pulse
// R08: action field changed only while off
// R09: level bit sets initial compare level
// R10: level bit sets PWM active level
// R11: polarity bit inverts pin, not timer mode
// R12: read-only direction flag, 1 down
// R13: clear select: 1 comparator A, 0 P
// R14: comparator B never clears counter
// R15: overflow clear only when period zero
// R16: clear select ignored outside compare/timer
// R17: capture edge copies counter to compare A
// R18: on rising clears counter, off holds
// R19: period bits match counter bits 9..7
// R20: capture edge: rise, fall, both, off
module tmca_channel #(
   parameter CNT_W = 10
) (
   input  wire        clk_in,
   input  wire        resetn_in,
   input  wire [3:0]  avs_address_in,
   input  wire        avs_read_in,
   input  wire        avs_write_in,
   input  wire [31:0] avs_writedata_in,
   input  wire [3:0]  avs_byteenable_in,
   output reg  [31:0] avs_readdata_out,
   output reg         avs_waitrequest_out,
   input  wire        chan_a_pin_in,
   output reg         chan_a_pin_out,
   output reg         chan_a_pin_oe_out,
   output reg         match_a_out,
   output reg         match_p_out
);
   // ************************************************************
   // registers
   // ************************************************************
   reg  [7:0]       ctrl_q;
   reg  [7:0]       timer_q;
   reg  [CNT_W-1:0] cmpa_q;
   reg  [CNT_W-1:0] count_q;
   reg              down_q;
   reg              on_prev_q;
   reg              level_q;
   reg              pin_prev_q;
   reg              pulse_done_q;
   reg              ack_q;
   wire             pin_sync;

   wire [1:0] mode      = {ctrl_q[`TMCA_MODE_HI_BIT], ctrl_q[`TMCA_MODE_LO_BIT]};
   wire [1:0] action    = {ctrl_q[`TMCA_ACT_HI_BIT], ctrl_q[`TMCA_ACT_LO_BIT]};
   wire       init_lvl  = ctrl_q[`TMCA_LEVEL_BIT];
   wire       pol       = ctrl_q[`TMCA_POL_BIT];
   wire       clr_sel   = ctrl_q[`TMCA_CLR_BIT];
   wire       timer_on  = timer_q[`TMCA_TIMER_ON_BIT];
   wire       down_req  = timer_q[`TMCA_TIMER_DOWN_BIT];
   wire [2:0] period    = timer_q[`TMCA_PERIOD_LSB+2:`TMCA_PERIOD_LSB];
   wire       on_rise   = timer_on & ~on_prev_q;

   tmca_pin_sync u_sync (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .async_in  (chan_a_pin_in),
      .sync_out  (pin_sync)
   );

   // ************************************************************
   // bus slave: one wait cycle per access
   // ************************************************************
   wire req     = (avs_read_in | avs_write_in) & ~ack_q;
   wire wr_take = avs_write_in & ack_q;

   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ack_q <= 1'b0;
         avs_waitrequest_out <= 1'b1;
      end else begin
         ack_q <= req;
         avs_waitrequest_out <= ~req;
      end
   end

   // ************************************************************
   // register readback
   // ************************************************************
   reg [31:0] rdata_d;
   always @* begin
      case (avs_address_in)
         `TMCA_OFF_CTRL:  rdata_d = {24'h00_0000, ctrl_q[7:2], down_q, ctrl_q[0]}; // R12
         `TMCA_OFF_TIMER: rdata_d = {24'h00_0000, timer_q};
         `TMCA_OFF_CMPA:  rdata_d = {22'h00_0000, cmpa_q};
         `TMCA_OFF_COUNT: rdata_d = {22'h00_0000, count_q};
         default:         rdata_d = 32'h0000_0000;
      endcase
   end

   // data captured at the take edge, stands at the answer edge
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         avs_readdata_out <= 32'h0000_0000;
      end else if (req && avs_read_in) begin
         avs_readdata_out <= rdata_d;
      end
   end

   // ************************************************************
   // comparators and counter
   // ************************************************************
   wire match_a   = (count_q == cmpa_q);
   wire match_p   = (count_q[CNT_W-1:CNT_W-3] == period) && (period != 3'h0); // R19
   wire top       = &count_q;
   wire clr_allow = (mode == `TMCA_MODE_CMP) || (mode == `TMCA_MODE_TMR); // R16
   // comparator B is not an input; it cannot clear R14
   wire clr_hit   = clr_allow & (clr_sel ? match_a : match_p); // R13
   wire ovf_clr   = (clr_sel == 1'b0) && (period == 3'h0) && top; // R15
   wire pwm_clr   = ~clr_allow & (match_p | ((period == 3'h0) & top));

   // ************************************************************
   // counter next value
   // ************************************************************
   reg [CNT_W-1:0] count_d;
   always @* begin
      count_d = count_q;
      if (on_rise) begin
         count_d = {CNT_W{1'b0}}; // R18
      end else if (timer_on) begin
         if (clr_hit || ovf_clr || pwm_clr) begin
            count_d = {CNT_W{1'b0}};
         end else if (down_q) begin
            count_d = count_q - {{(CNT_W-1){1'b0}}, 1'b1};
         end else begin
            count_d = count_q + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // off holds the residual count
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         count_q <= {CNT_W{1'b0}};
      end else begin
         count_q <= count_d; // R18
      end
   end

   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         down_q    <= 1'b0;
         on_prev_q <= 1'b0;
      end else begin
         on_prev_q <= timer_on;
         down_q    <= down_req & timer_on; // R12
      end
   end

   // ************************************************************
   // control registers and capture
   // ************************************************************
   wire rise_edge = pin_sync & ~pin_prev_q;
   wire fall_edge = ~pin_sync & pin_prev_q;
   reg  cap_edge;
   always @* begin
      case (action) // R20
         2'h0:    cap_edge = rise_edge;
         2'h1:    cap_edge = fall_edge;
         2'h2:    cap_edge = rise_edge | fall_edge;
         default: cap_edge = 1'b0;
      endcase
   end

   // ************************************************************
   // write decode
   // ************************************************************
   wire wr_ctrl  = wr_take && (avs_address_in == `TMCA_OFF_CTRL) && avs_byteenable_in[0];
   wire wr_timer = wr_take && (avs_address_in == `TMCA_OFF_TIMER) && avs_byteenable_in[0];
   wire wr_cmpa  = wr_take && (avs_address_in == `TMCA_OFF_CMPA);
   wire cap_take = (mode == `TMCA_MODE_CAP) && timer_on && cap_edge; // R17

   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pin_prev_q <= 1'b0;
      end else begin
         pin_prev_q <= pin_sync;
      end
   end

   // direction bit never stored
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctrl_q <= `TMCA_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= avs_writedata_in[7:0] & 8'hFD; // R01
      end
   end

   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         timer_q <= `TMCA_TIMER_RESET;
      end else if (wr_timer) begin
         timer_q <= avs_writedata_in[7:0];
      end
   end

   // capture wins over a software write
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cmpa_q <= `TMCA_CMPA_RESET;
      end else if (cap_take) begin
         cmpa_q <= count_q; // R17
      end else if (wr_cmpa) begin
         if (avs_byteenable_in[0]) cmpa_q[7:0] <= avs_writedata_in[7:0];
         if (avs_byteenable_in[1]) cmpa_q[CNT_W-1:8] <= avs_writedata_in[CNT_W-1:8];
      end
   end

   // ************************************************************
   // output level generation
   // ************************************************************
   reg lvl_d;
   always @* begin
      lvl_d = level_q;
      case (mode)
         `TMCA_MODE_CMP: begin
            if (on_rise) begin
               lvl_d = init_lvl; // R06 R09
            end else if (timer_on && match_a) begin
               case (action) // R04 R05
                  2'h1:    lvl_d = 1'b0;
                  2'h2:    lvl_d = 1'b1;
                  2'h3:    lvl_d = ~level_q;
                  default: lvl_d = level_q;
               endcase
            end
         end
         `TMCA_MODE_PWM: begin
            case (action) // R07 R10
               2'h0:    lvl_d = ~init_lvl;
               2'h1:    lvl_d = init_lvl;
               2'h2:    lvl_d = (count_q < cmpa_q) ? init_lvl : ~init_lvl;
               default: lvl_d = (timer_on && !pulse_done_q && count_q < cmpa_q) ? init_lvl : ~init_lvl;
            endcase
         end
         default: lvl_d = level_q;
      endcase
   end

   // ************************************************************
   // single pulse tracking
   // ************************************************************
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pulse_done_q <= 1'b0;
      end else if (on_rise) begin
         pulse_done_q <= 1'b0;
      end else if (timer_on && match_a && cmpa_q != {CNT_W{1'b0}}) begin
         pulse_done_q <= 1'b1;
      end
   end

   // ************************************************************
   // pin outputs
   // ************************************************************
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         level_q           <= 1'b0;
         chan_a_pin_out    <= 1'b0;
         chan_a_pin_oe_out <= 1'b0;
         match_a_out       <= 1'b0;
         match_p_out       <= 1'b0;
      end else begin
         level_q           <= lvl_d;
         chan_a_pin_out    <= lvl_d ^ pol; // R11
         // timer and capture modes do not drive the pin R03
         chan_a_pin_oe_out <= (mode == `TMCA_MODE_CMP) || (mode == `TMCA_MODE_PWM);
         match_a_out       <= timer_on & match_a;
         match_p_out       <= timer_on & match_p;
      end
   end
endmodule
`default_nettype wire

// ---- design/tmca_regs.vh ----
// Purpose: constants for the timer channel A control block
// Assumes: Avalon-MM 32-bit words, byte addresses
// Notes:   one control register plus helper registers
`ifndef TMCA_REGS_VH
`define TMCA_REGS_VH

`define TMCA_OFF_CTRL        4'h0
`define TMCA_OFF_TIMER       4'h4
`define TMCA_OFF_CMPA        4'h8
`define TMCA_OFF_COUNT       4'hC

`define TMCA_CTRL_RESET      8'h00
`define TMCA_TIMER_RESET     8'h00
`define TMCA_CMPA_RESET      10'h000

`define TMCA_MODE_HI_BIT     7
`define TMCA_MODE_LO_BIT     6
`define TMCA_ACT_HI_BIT      5
`define TMCA_ACT_LO_BIT      4
`define TMCA_LEVEL_BIT       3
`define TMCA_POL_BIT         2
`define TMCA_DIR_BIT         1
`define TMCA_CLR_BIT         0

`define TMCA_TIMER_ON_BIT    0
`define TMCA_TIMER_DOWN_BIT  1
`define TMCA_PERIOD_LSB      4

`define TMCA_MODE_CMP        2'h0
`define TMCA_MODE_CAP        2'h1
`define TMCA_MODE_PWM        2'h2
`define TMCA_MODE_TMR        2'h3

`endif

// ---- design/tmca_pin_sync.v ----
// Purpose: two-flop synchroniser for the channel A pin
// Assumes: single clock domain
// Notes:   first flop read only by second flop
`timescale 1ns/1ps
`default_nettype none
module tmca_pin_sync (
   input  wire clk_in,
   input  wire resetn_in,
   input  wire async_in,
   output wire sync_out
);
   reg meta_q;
   reg sync_q;
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
   assign sync_out = sync_q;
endmodule
`default_nettype wire

// ---- bench/tmca_channel_asserts.sv ----
// Purpose: port checker for tmca_channel
// Assumes: all byte lanes enabled on writes
// Notes:   control and timer state mirrored from bus writes
`timescale 1ns/1ps
`default_nettype none
module tmca_channel_asserts #(
   parameter CNT_W = 10
) (
   input wire logic        clk_in,
   input wire logic        resetn_in,
   input wire logic [3:0]  avs_address_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0]  avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out,
   input wire logic        chan_a_pin_in,
   input wire logic        chan_a_pin_out,
   input wire logic        chan_a_pin_oe_out,
   input wire logic        match_a_out,
   input wire logic        match_p_out
);
   logic [7:0] ctl_q;
   logic [7:0] tmr_q;
   logic [1:0] age_q;
   logic       wr_ok;
   logic       rd_ctl;
   logic [7:0] rdb;
   assign wr_ok  = avs_write_in && !avs_waitrequest_out;
   assign rd_ctl = avs_read_in && !avs_waitrequest_out && avs_address_in == 4'h0;
   assign rdb    = avs_readdata_out[7:0];
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctl_q <= 8'h00;
         tmr_q <= 8'h00;
         age_q <= 2'h0;
      end else begin
         if (wr_ok && avs_address_in == 4'h0) ctl_q <= avs_writedata_in[7:0];
         if (wr_ok && avs_address_in == 4'h4) tmr_q <= avs_writedata_in[7:0];
         age_q <= wr_ok ? 2'h0 : (age_q == 2'h3 ? age_q : age_q + 2'h1);
      end
   end
   // ****
   // checks
   // ****
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   AST_TAKE: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("request not answered");
   AST_ONE: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("answer longer than one cycle");
   AST_CTRL_RD: assert property (rd_ctl |-> (rdb & 8'hFD) == (ctl_q & 8'hFD))
      else $error("control readback wrong");
   AST_DIR: assert property (rd_ctl |-> rdb[1] == (tmr_q[1:0] == 2'h3))
      else $error("direction flag wrong");
   AST_OE: assert property (age_q == 2'h3 |-> chan_a_pin_oe_out == !ctl_q[6])
      else $error("pin enable wrong for mode");
   AST_FORCED: assert property (age_q == 2'h3 && tmr_q[0] && ctl_q[7:5] == 3'h4 |-> chan_a_pin_out == ((ctl_q[4] ~^ ctl_q[3]) ^ ctl_q[2]))
      else $error("forced level wrong");
   AST_START: assert property (wr_ok && avs_address_in == 4'h4 && avs_writedata_in[0] && !tmr_q[0] && ctl_q[7:6] == 2'h0
      |-> ##[1:2] chan_a_pin_out == (ctl_q[3] ^ ctl_q[2]))
      else $error("start level wrong");
   AST_MATCH: assert property ($rose(match_a_out) && age_q == 2'h3 && ctl_q[7:6] == 2'h0 && (ctl_q[5] ^ ctl_q[4])
      |-> ##[0:2] chan_a_pin_out == (ctl_q[5] ^ ctl_q[2]))
      else $error("match level wrong");
   cover property (match_a_out && ctl_q[0]);
   cover property (rd_ctl && rdb[1]);
   cover property (age_q == 2'h3 && ctl_q[7:6] == 2'h1);
endmodule
bind tmca_channel tmca_channel_asserts #(.CNT_W(CNT_W)) u_asserts (.clk_in(clk_in), .resetn_in(resetn_in),
   .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .chan_a_pin_in(chan_a_pin_in), .chan_a_pin_out(chan_a_pin_out), .chan_a_pin_oe_out(chan_a_pin_oe_out),
   .match_a_out(match_a_out), .match_p_out(match_p_out));
`default_nettype wire

// ---- bench/tmca_pin_model.sv ----
// Purpose: external source on the channel A pin
// Assumes: one driver on the wire at a time
// Notes:   design owns the wire while its enable is high
`timescale 1ns/1ps
`default_nettype none
module tmca_pin_model (
   input  wire logic dut_oe_in,
   input  wire logic dut_level_in,
   input  wire logic ext_level_in,
   output logic      pin_out
);
   assign pin_out = dut_oe_in ? dut_level_in : ext_level_in;
endmodule
`default_nettype wire

// ---- bench/tmca_channel_bench.sv ----
// Purpose: self-checking bench for tmca_channel
// Assumes: 40 MHz clock, 10 cycles of reset
// Notes:   timer stopped before every mode or action change
`timescale 1ns/1ps
`default_nettype none
module tmca_channel_bench;
   logic        clk_in = 1'h0;
   logic        resetn_in = 1'h0;
   logic        rd = 1'h0;
   logic        wr = 1'h0;
   logic        ext = 1'h0;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wd = 32'h0000_0000;
   logic [31:0] rdat;
   logic [31:0] q;
   logic        wq, pin, po, oe, ma, mp;
   int          bad_count = 0;
   int          check_count = 0;
   always #12.5 clk_in = ~clk_in;
   tmca_channel dut (.clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(adr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF), .avs_readdata_out(rdat),
      .avs_waitrequest_out(wq), .chan_a_pin_in(pin), .chan_a_pin_out(po), .chan_a_pin_oe_out(oe),
      .match_a_out(ma), .match_p_out(mp));
   tmca_pin_model pm (.dut_oe_in(oe), .dut_level_in(po), .ext_level_in(ext), .pin_out(pin));
   // ****
   // tasks
   // ****
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [9:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      adr <= a;
      wd <= {22'h00_0000, d};
      wr <= w;
      rd <= !w;
      do @(posedge clk_in); while (wq !== 1'h0 && ++n < 20);
      chk(wq, 1'h0);
      q = rdat;
      wr <= 1'h0;
      rd <= 1'h0;
   endtask
   task automatic t_regs;
      bus(1'h0, 4'h0, 10'h000);
      chk(q, 32'h0000_0000);
      bus(1'h1, 4'h0, 10'h0FF);
      bus(1'h0, 4'h0, 10'h000);
      chk(q[7:0], 8'hFD);
      bus(1'h1, 4'h0, 10'h000);
      bus(1'h1, 4'h4, 10'h003);
      bus(1'h0, 4'h0, 10'h000);
      chk(q[1], 1'h1);
      bus(1'h1, 4'h4, 10'h000);
   endtask
   task automatic t_modes;
      bus(1'h1, 4'h8, 10'h200);
      for (int m = 0; m < 4; m++) begin
         bus(1'h1, 4'h0, 10'h018 + 10'(m * 64));
         bus(1'h1, 4'h4, 10'h001);
         repeat (4) @(posedge clk_in);
         chk(oe, !m[0]);
         if (!m[0]) chk(po, 1'h1);
         bus(1'h1, 4'h4, 10'h000);
      end
   endtask
   task automatic t_cmp;
      logic l, p, e;
      bus(1'h1, 4'h8, 10'h028);
      for (int i = 0; i < 16; i++) begin
         l = i[2];
         p = i[3];
         e = i[1:0] == 0 ? l : (i[1:0] == 3 ? !l : i[1]);
         bus(1'h1, 4'h0, {4'h0, i[1:0], l, p, 2'h1});
         bus(1'h1, 4'h4, 10'h001);
         repeat (2) @(posedge clk_in);
         chk(po, l ^ p);
         for (int n = 0; n < 300 && ma !== 1'h1; n++) @(posedge clk_in);
         chk(ma, 1'h1);
         repeat (3) @(posedge clk_in);
         chk(po, e ^ p);
         bus(1'h1, 4'h4, 10'h000);
      end
   endtask
   task automatic t_clr;
      bus(1'h1, 4'h8, 10'h014);
      for (int c = 0; c < 3; c++) begin
         bus(1'h1, 4'h0, c == 2 ? 10'h081 : 10'(c));
         bus(1'h1, 4'h4, 10'h001);
         repeat (50) @(posedge clk_in);
         bus(1'h0, 4'hC, 10'h000);
         chk(q <= 32'h0000_0014, c == 1);
         bus(1'h1, 4'h4, 10'h000);
      end
   endtask
   task automatic t_period;
      int n;
      n = 0;
      bus(1'h1, 4'h0, 10'h000);
      bus(1'h1, 4'h4, 10'h011);
      while (mp !== 1'h1 && n < 300) begin
         @(posedge clk_in);
         n++;
      end
      chk(mp, 1'h1);
      bus(1'h0, 4'hC, 10'h000);
      chk(q <= 32'h0000_0080, 1'h1);
      bus(1'h1, 4'h4, 10'h000);
   endtask
   // edge 3 cycles after pin change (2 sync flops); stop 7 cycles after capture
   task automatic cap_run(input logic lvl, input logic hit);
      logic [31:0] v;
      bus(1'h1, 4'h8, 10'h3FF);
      bus(1'h1, 4'h4, 10'h001);
      repeat (30) @(posedge clk_in);
      ext <= lvl;
      repeat (6) @(posedge clk_in);
      bus(1'h1, 4'h4, 10'h000);
      bus(1'h0, 4'hC, 10'h000);
      v = q;
      bus(1'h0, 4'h8, 10'h000);
      chk(q, hit ? v - 32'h0000_0007 : 32'h0000_03FF);
      bus(1'h0, 4'hC, 10'h000);
      chk(q, v);
   endtask
   task automatic t_cap;
      for (int e = 0; e < 4; e++) begin
         bus(1'h1, 4'h0, 10'h040 + 10'(e * 16));
         cap_run(1'h1, e == 0 || e == 2);
         cap_run(1'h0, e == 1 || e == 2);
      end
   endtask
   task automatic report_and_stop;
      $display("checks=%0d errors=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_in);
      resetn_in <= 1'h1;
      t_regs;
      t_modes;
      t_cmp;
      t_clr;
      t_period;
      t_cap;
      report_and_stop;
   end
   // about ten times the expected run
   initial begin
      #500_000;
      bad_count++;
      report_and_stop;
   end
endmodule
`default_nettype wire
